// ### hw/pmc_bank.sv
// Power management capability bank: capability word, control/status word
// and a lock word, reached over an AXI4-Lite slave port.
// Assumes one clock, a synchronous active-low reset and a well-behaved
// AXI4-Lite master with at most one write and one read in flight.
`timescale 1ns/100ps

// Functional notes
// - Capability identifier reads fixed 0x1
// - Next capability pointer reads fixed 0x0
// - Revision field reads fixed 0x2
// - Event clock, bus state, bus power bits zero
// - Special init bit resets zero, lock-gated writes
// - Aux current field reads zero, ignores writes
// - Event support field reads zero
// - Power state readable, writable: D0 or D3hot
// - Event enable bit hard-wired zero
// - Data select and scale fields read zero
// - Event status bit hard-wired zero
// - Optional data byte reads zero
module pmc_bank
    import pmc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Function power state towards the endpoint core
    output logic [1:0] power_state
);

    // Word-aligned address decode, shared by reads and writes
    function automatic pmc_sel_e pmc_decode(input logic [11:0] addr);
        pmc_decode = PMC_SEL_NONE;
        if (addr[11:2] == PMC_OFF_CAP[11:2]) begin
            pmc_decode = PMC_SEL_CAP;
        end else if (addr[11:2] == PMC_OFF_CSR[11:2]) begin
            pmc_decode = PMC_SEL_CSR;
        end else if (addr[11:2] == PMC_OFF_LOCK[11:2]) begin
            pmc_decode = PMC_SEL_LOCK;
        end
    endfunction : pmc_decode

    // Read value of a register; every unlisted bit is zero
    function automatic logic [31:0] pmc_read_word(input pmc_sel_e sel,
                                                  input pmc_state_s st);
        // Start from all zero so every reserved bit and every fixed field not set below reads zero
        pmc_read_word = '0;
        unique case (sel)
            PMC_SEL_CAP: begin
                pmc_read_word[PMC_CAP_ID_LSB +: 8] = PMC_CAP_ID_VAL;
                pmc_read_word[PMC_NEXT_PTR_LSB +: 8] = PMC_NEXT_PTR_VAL;
                pmc_read_word[PMC_REV_LSB +: 3] = PMC_REV_VAL;
                // Event clock, aux current, D1/D2, event support stay zero
                pmc_read_word[PMC_SPECIAL_INIT_BIT] = st.special_init;
            end
            PMC_SEL_CSR: begin
                // Only the state field is live; upper bits stay zero
                pmc_read_word[PMC_PWR_STATE_LSB +: 2] = st.pwr_state;
            end
            PMC_SEL_LOCK: begin
                pmc_read_word[PMC_UNLOCK_BIT] = st.unlock;
            end
            PMC_SEL_NONE: begin
                pmc_read_word = '0;
            end
        endcase
    endfunction : pmc_read_word

    // State register and its next value
    pmc_state_s st_q;
    pmc_state_s st_d;

    // Channel handshakes in this cycle
    logic aw_take;
    logic w_take;
    logic ar_take;
    // Effective write request, whether held or arriving now
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_fire;
    pmc_sel_e wr_sel;
    pmc_sel_e rd_sel;

    // Ready stalls while a request is parked or a response is pending
    assign s_axi_awready = !st_q.aw_have && !st_q.b_valid;
    assign s_axi_wready = !st_q.w_have && !st_q.b_valid;
    assign s_axi_arready = !st_q.r_valid;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    // Address and data may come in either order
    assign wr_addr = st_q.aw_have ? st_q.aw_addr : s_axi_awaddr;
    assign wr_data = st_q.w_have ? st_q.w_data : s_axi_wdata;
    assign wr_strb = st_q.w_have ? st_q.w_strb : s_axi_wstrb;
    assign wr_fire = (st_q.aw_have || aw_take) && (st_q.w_have || w_take);
    assign wr_sel = pmc_decode(wr_addr);
    assign rd_sel = pmc_decode(s_axi_araddr);

    // Next-state logic for bus channels and register fields
    always_comb begin
        st_d = st_q;
        // Park an early address or data beat
        if (aw_take) begin
            st_d.aw_have = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (w_take) begin
            st_d.w_have = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
        end
        // Retire a delivered write response
        if (st_q.b_valid && s_axi_bready) begin
            st_d.b_valid = 1'b0;
        end
        // Commit a complete write; fixed fields have no storage at all
        if (wr_fire) begin
            st_d.aw_have = 1'b0;
            st_d.w_have = 1'b0;
            st_d.b_valid = 1'b1;
            st_d.b_resp = PMC_RESP_OKAY;
            unique case (wr_sel)
                PMC_SEL_CAP: begin
                    // Special init bit only moves while unlocked
                    if (wr_strb[PMC_LANE_SPECIAL] && st_q.unlock) begin
                        st_d.special_init = wr_data[PMC_SPECIAL_INIT_BIT];
                    end
                end
                PMC_SEL_CSR: begin
                    // D1/D2 codes are dropped so the core never sees them
                    if (wr_strb[PMC_LANE_PWR_STATE]) begin
                        if (wr_data[PMC_PWR_STATE_LSB +: 2] == PMC_PWR_STATE_D0 ||
                            wr_data[PMC_PWR_STATE_LSB +: 2] == PMC_PWR_STATE_D3HOT) begin
                            st_d.pwr_state = wr_data[PMC_PWR_STATE_LSB +: 2];
                        end
                    end
                end
                PMC_SEL_LOCK: begin
                    if (wr_strb[PMC_LANE_UNLOCK]) begin
                        st_d.unlock = wr_data[PMC_UNLOCK_BIT];
                    end
                end
                PMC_SEL_NONE: begin
                    // Unmapped write: nothing stored, error answered
                    st_d.b_resp = PMC_RESP_SLVERR;
                end
            endcase
        end
        // Read: capture the word once, hold it until taken
        if (ar_take) begin
            st_d.r_valid = 1'b1;
            st_d.r_sel = rd_sel;
            st_d.r_data = pmc_read_word(rd_sel, st_q);
            st_d.r_resp = (rd_sel == PMC_SEL_NONE) ? PMC_RESP_SLVERR : PMC_RESP_OKAY;
        end else if (st_q.r_valid && s_axi_rready) begin
            st_d.r_valid = 1'b0;
        end
    end

    // State register with synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
            st_q.r_sel <= PMC_SEL_NONE;
            st_q.pwr_state <= PMC_PWR_STATE_RST;
            st_q.special_init <= PMC_SPECIAL_INIT_RST;
            st_q.unlock <= PMC_UNLOCK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flops
    assign s_axi_bvalid = st_q.b_valid;
    assign s_axi_bresp = st_q.b_resp;
    assign s_axi_rvalid = st_q.r_valid;
    assign s_axi_rdata = st_q.r_data;
    assign s_axi_rresp = st_q.r_resp;
    assign power_state = st_q.pwr_state;

    // Checks on the design's own behaviour
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Helpers naming a committed write per target
    logic csr_write;
    logic cap_write;
    assign csr_write = wr_fire && wr_sel == PMC_SEL_CSR && wr_strb[PMC_LANE_PWR_STATE];
    assign cap_write = wr_fire && wr_sel == PMC_SEL_CAP && wr_strb[PMC_LANE_SPECIAL];

    // A legal state code arrives
    sequence s_legal_state_write;
        csr_write && (wr_data[1:0] == 2'h0 || wr_data[1:0] == 2'h3);
    endsequence
    // A reserved state code arrives
    sequence s_reserved_state_write;
        csr_write && (wr_data[1:0] == 2'h1 || wr_data[1:0] == 2'h2);
    endsequence
    // The special init bit is offered while the gate is open
    sequence s_open_init_write;
        cap_write && st_q.unlock;
    endsequence

    a_cap_id_pointer: assert property (
        s_axi_rvalid && st_q.r_sel == PMC_SEL_CAP |-> s_axi_rdata[15:0] == 16'h0001)
        else $error("capability id or next pointer wrong");

    a_cap_next_zero: assert property (
        ar_take && rd_sel == PMC_SEL_CAP |=> s_axi_rdata[15:8] == 8'h00)
        else $error("next pointer not zero");

    a_cap_revision: assert property (
        ar_take && rd_sel == PMC_SEL_CAP |=> s_axi_rvalid && s_axi_rdata[18:16] == 3'h2)
        else $error("revision field not two");

    a_cap_zero_bits: assert property (
        s_axi_rvalid && st_q.r_sel == PMC_SEL_CAP
        |-> s_axi_rdata[31:22] == 10'h000 && s_axi_rdata[20:19] == 2'h0)
        else $error("fixed capability bits not zero");

    a_csr_zero_bits: assert property (
        s_axi_rvalid && st_q.r_sel == PMC_SEL_CSR |-> s_axi_rdata[31:2] == 30'h0)
        else $error("control word fixed bits not zero");

    a_state_write_taken: assert property (
        s_legal_state_write |=> power_state == $past(wr_data[1:0]))
        else $error("legal power state not stored");

    a_state_reserved_hold: assert property (
        s_reserved_state_write |=> $stable(power_state))
        else $error("reserved power state adopted");

    a_special_locked: assert property (
        cap_write && !st_q.unlock |=> $stable(st_q.special_init))
        else $error("special init changed while locked");

    a_reset_values: assert property (
        $rose(aresetn) |-> power_state == 2'h0 && !st_q.special_init)
        else $error("reset values wrong");

    a_write_answer: assert property (
        wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write not answered next cycle");

    a_read_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");

    // With the gate open the written bit must land one cycle later
    a_init_gate_open: assert property (
        s_open_init_write |=> st_q.special_init == $past(wr_data[21]))
        else $error("special init not stored while unlocked");

    // Only D0 and D3hot may ever reach the endpoint core;
    // a reserved code leaking out would confuse its power sequencing
    a_state_legal_only: assert property (
        power_state == 2'h0 || power_state == 2'h3)
        else $error("power state holds a reserved code");

    // An unmapped write stores nothing and is answered with an error
    a_unmapped_write: assert property (
        wr_fire && wr_sel == PMC_SEL_NONE
        |=> s_axi_bresp == PMC_RESP_SLVERR && $stable(power_state))
        else $error("unmapped write not refused");

    // An unmapped read returns zero data with an error
    a_unmapped_read: assert property (
        ar_take && rd_sel == PMC_SEL_NONE
        |=> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == PMC_RESP_SLVERR)
        else $error("unmapped read not refused");

    // A taken read is answered next cycle and blocks further reads
    a_read_answer: assert property (
        ar_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");

endmodule : pmc_bank

// ### hw/pmc_pkg.sv
// Constants and types for the power management capability register bank.
// Assumes a 32-bit AXI4-Lite slave port with a 12-bit byte address.
package pmc_pkg;

    // Bus widths
    localparam int PMC_ADDR_W = 12;
    localparam int PMC_DATA_W = 32;

    // Register byte offsets
    localparam logic [11:0] PMC_OFF_CAP = 12'h0F0;  // pm_capabilities
    localparam logic [11:0] PMC_OFF_CSR = 12'h0F4;  // pm_control_status
    localparam logic [11:0] PMC_OFF_LOCK = 12'h100;  // pm_lock_control

    // Capabilities word fields
    localparam int PMC_CAP_ID_LSB = 0;
    localparam logic [7:0] PMC_CAP_ID_VAL = 8'h01;
    localparam int PMC_NEXT_PTR_LSB = 8;
    localparam logic [7:0] PMC_NEXT_PTR_VAL = 8'h00;
    localparam int PMC_REV_LSB = 16;
    localparam logic [2:0] PMC_REV_VAL = 3'h2;
    localparam int PMC_SPECIAL_INIT_BIT = 21;
    localparam logic PMC_SPECIAL_INIT_RST = 1'b0;

    // Control/status word fields
    localparam int PMC_PWR_STATE_LSB = 0;
    localparam logic [1:0] PMC_PWR_STATE_D0 = 2'h0;
    localparam logic [1:0] PMC_PWR_STATE_D3HOT = 2'h3;
    localparam logic [1:0] PMC_PWR_STATE_RST = 2'h0;

    // Lock control word fields
    localparam int PMC_UNLOCK_BIT = 0;
    localparam logic PMC_UNLOCK_RST = 1'b0;

    // Byte lanes holding writable fields
    localparam int PMC_LANE_PWR_STATE = 0;
    localparam int PMC_LANE_SPECIAL = 2;
    localparam int PMC_LANE_UNLOCK = 0;

    // Bus response codes
    localparam logic [1:0] PMC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PMC_RESP_SLVERR = 2'h2;

    // Register selected by an address
    typedef enum logic [3:0] {
        PMC_SEL_NONE = 4'b0001,
        PMC_SEL_CAP = 4'b0010,
        PMC_SEL_CSR = 4'b0100,
        PMC_SEL_LOCK = 4'b1000
    } pmc_sel_e;

    // Whole state of the bank
    typedef struct packed {
        logic aw_have;
        logic [11:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic b_valid;
        logic [1:0] b_resp;
        logic r_valid;
        logic [31:0] r_data;
        logic [1:0] r_resp;
        pmc_sel_e r_sel;
        logic [1:0] pwr_state;
        logic special_init;
        logic unlock;
    } pmc_state_s;

endpackage : pmc_pkg

// ### verification/ntb_power_mgmt_capability_tb.sv
// Self-checking bench for the power management capability register bank.
// Assumes one 200 MHz clock and drives the AXI4-Lite slave port directly.
`timescale 1ns/100ps

// Compare one value with its expectation, count it, report a mismatch
`define CHK(nm, ex, ac) begin num_checks++; if ((ac) !== (ex)) begin n_fail++; \
    $display("unexpected %s expected %h seen %h", nm, ex, ac); end end

module ntb_power_mgmt_capability_tb;
    import pmc_pkg::*;

    // Clock and reset
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    // Write channels
    logic [11:0] awaddr = 12'h000;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b1;
    // Read channels
    logic [11:0] araddr = 12'h000;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b1;
    // Power state towards the core
    logic [1:0] power_state;
    // Bookkeeping
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;

    // 200 MHz clock
    always #2.5 aclk = ~aclk;

    // Device under test
    pmc_bank dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .power_state(power_state)
    );

    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Hang guard, far above the roughly 70 cycles the tests need
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            wrap_up();
        end
    end

    // One write; handshakes sampled mid-cycle, where inputs are settled
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] s, input logic [1:0] er);
        logic aw_tk;
        logic w_tk;
        logic b_tk;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        b_tk = 1'b0;
        while (!b_tk) begin
            @(negedge aclk);
            aw_tk = awvalid && awready;
            w_tk = wvalid && wready;
            b_tk = bvalid;
            if (b_tk) begin
                `CHK("bresp", er, bresp)
            end
            @(posedge aclk);
            // Release each half at the edge it is taken
            if (aw_tk) begin
                awvalid <= 1'b0;
            end
            if (w_tk) begin
                wvalid <= 1'b0;
            end
        end
    endtask : axi_wr

    // One read with expected data and response
    task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        logic ar_tk;
        logic r_tk;
        araddr <= a;
        arvalid <= 1'b1;
        r_tk = 1'b0;
        while (!r_tk) begin
            @(negedge aclk);
            ar_tk = arvalid && arready;
            r_tk = rvalid;
            if (r_tk) begin
                `CHK("rdata", ed, rdata)
                `CHK("rresp", er, rresp)
            end
            @(posedge aclk);
            if (ar_tk) begin
                arvalid <= 1'b0;
            end
        end
    endtask : axi_rd

    // Look at the power state output once it has settled
    task automatic chk_state(input logic [1:0] ex);
        @(negedge aclk);
        `CHK("power_state", ex, power_state)
        @(posedge aclk);
    endtask : chk_state

    // Synchronous reset held for the given number of edges
    task automatic do_reset(input int n);
        aresetn <= 1'b0;
        repeat (n) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : do_reset

    // Main sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset images of both words
        axi_rd(PMC_OFF_CAP, 32'h0002_0001, PMC_RESP_OKAY);
        axi_rd(PMC_OFF_CSR, 32'h0000_0000, PMC_RESP_OKAY);
        chk_state(PMC_PWR_STATE_D0);
        // All-ones into the fixed word while locked: nothing may stick
        axi_wr(PMC_OFF_CAP, 32'hFFFF_FFFF, 4'hF, PMC_RESP_OKAY);
        axi_rd(PMC_OFF_CAP, 32'h0002_0001, PMC_RESP_OKAY);
        // All-ones into control: only the state field takes D3hot
        axi_wr(PMC_OFF_CSR, 32'hFFFF_FFFF, 4'hF, PMC_RESP_OKAY);
        axi_rd(PMC_OFF_CSR, 32'h0000_0003, PMC_RESP_OKAY);
        chk_state(PMC_PWR_STATE_D3HOT);
        // Deliberate misuse: reserved codes from D3hot keep the held state
        axi_wr(PMC_OFF_CSR, 32'h0000_0001, 4'hF, PMC_RESP_OKAY);
        chk_state(PMC_PWR_STATE_D3HOT);
        axi_wr(PMC_OFF_CSR, 32'h0000_0002, 4'hF, PMC_RESP_OKAY);
        axi_rd(PMC_OFF_CSR, 32'h0000_0003, PMC_RESP_OKAY);
        // Back to D0, then a write with lane 0 disabled does nothing
        axi_wr(PMC_OFF_CSR, 32'h0000_0000, 4'h1, PMC_RESP_OKAY);
        chk_state(PMC_PWR_STATE_D0);
        axi_wr(PMC_OFF_CSR, 32'h0000_0003, 4'hE, PMC_RESP_OKAY);
        axi_rd(PMC_OFF_CSR, 32'h0000_0000, PMC_RESP_OKAY);
        // Unlock, then the special init bit becomes writable
        axi_wr(PMC_OFF_LOCK, 32'h0000_0001, 4'h1, PMC_RESP_OKAY);
        axi_rd(PMC_OFF_LOCK, 32'h0000_0001, PMC_RESP_OKAY);
        axi_wr(PMC_OFF_CAP, 32'hFFFF_FFFF, 4'hF, PMC_RESP_OKAY);
        axi_rd(PMC_OFF_CAP, 32'h0022_0001, PMC_RESP_OKAY);
        // Locked again: clearing attempt is ignored
        axi_wr(PMC_OFF_LOCK, 32'h0000_0000, 4'h1, PMC_RESP_OKAY);
        axi_wr(PMC_OFF_CAP, 32'h0000_0000, 4'hF, PMC_RESP_OKAY);
        axi_rd(PMC_OFF_CAP, 32'h0022_0001, PMC_RESP_OKAY);
        // Unmapped places answer with an error and store nothing
        axi_wr(12'h0F8, 32'hFFFF_FFFF, 4'hF, PMC_RESP_SLVERR);
        axi_rd(12'h0F8, 32'h0000_0000, PMC_RESP_SLVERR);
        axi_rd(12'h200, 32'h0000_0000, PMC_RESP_SLVERR);
        // Second reset in mid-run from D3hot with the init bit set
        axi_wr(PMC_OFF_CSR, 32'h0000_0003, 4'h1, PMC_RESP_OKAY);
        do_reset(2);
        chk_state(PMC_PWR_STATE_RST);
        axi_rd(PMC_OFF_CAP, 32'h0002_0001, PMC_RESP_OKAY);
        axi_rd(PMC_OFF_CSR, 32'h0000_0000, PMC_RESP_OKAY);
        wrap_up();
    end

endmodule : ntb_power_mgmt_capability_tb
